//--- logic/tosp_pkg.sv
package tosp_pkg;
  typedef enum logic [1:0] {
    TOSP_IDLE,
    TOSP_ARMED,
    TOSP_RUN,
    TOSP_HOLD
  } tosp_state_t;
endpackage

//--- logic/tosp_prescale.sv
`timescale 1ns/10ps
`include "tosp_regs.svh"
// Timer clock enable: system clock / 4, then prescale 2^sel
module tosp_prescale (
  // Clock, reset and enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Control
  input wire logic i_run,
  input wire logic [2:0] i_sel,
  // Ticks
  output logic o_tick,
  output logic [1:0] o_frac
);
  typedef struct packed {
    logic [1:0] q4;
    logic [6:0] pre;
    logic tick;
  } tosp_pre_t;
  tosp_pre_t s_q, s_d;
  logic [6:0] lim;

  always_comb begin
    lim = 7'(({7'h00, 1'b1} << i_sel) - 8'h01);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!i_run) begin
      s_d.q4 = 2'h0;
      s_d.pre = 7'h00;
    end else begin
      s_d.q4 = 2'(s_q.q4 + 2'h1);
      if (s_q.q4 == 2'h3) begin
        if (s_q.pre >= lim) begin
          s_d.pre = 7'h00;
          s_d.tick = 1'b1;
        end else begin
          s_d.pre = 7'(s_q.pre + 7'h01);
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;
  assign o_frac = s_q.pre[1:0];
endmodule

//--- logic/tosp_regs.svh
`ifndef TOSP_REGS_SVH
`define TOSP_REGS_SVH
// Register addresses
`define TOSP_A_PERIOD 4'h0
`define TOSP_A_DUTY_LO 4'h1
`define TOSP_A_DUTY_HI 4'h2
`define TOSP_A_CTRL 4'h3
`define TOSP_A_MODE 4'h4
`define TOSP_A_COMPARE 4'h5
`define TOSP_A_COUNT 4'h6
`define TOSP_A_STATUS 4'h7
`define TOSP_A_MASK 4'h8
// Timer control fields
`define TOSP_CTRL_ON 7
`define TOSP_CTRL_PRESCALE_SELECT_HI 6
`define TOSP_CTRL_PRESCALE_SELECT_LO 4
// Compare unit control fields
`define TOSP_CMP_EN 7
`define TOSP_CMP_FMT 4
// Operating select codes
`define TOSP_MODE_FREE 5'h00
`define TOSP_MODE_OS_RISE 5'h0c
`define TOSP_MODE_OS_FALL 5'h0d
// Status bits
`define TOSP_ST_MATCH 0
`define TOSP_ST_DUTY 1
`define TOSP_ST_TRIG 2
// Reset values
`define TOSP_RST_PERIOD 8'hff
`define TOSP_RST_BYTE 8'h00
// Restart holdoff in timer clocks after a reset edge
`define TOSP_RESTART_CLKS 2'h2
`endif

//--- logic/tosp_top.sv
`timescale 1ns/10ps
`include "tosp_regs.svh"
// Behaviour
// - One-shot mode starts counting on first qualifying edge after run set.
// - Later edges clear count; counting resumes two timer clocks later.
// - Mode code 01100 is rising-edge, 01101 falling-edge start and reset.
// - Period match in one-shot resets timer and clears run bit.
// - Trigger edges ignored while run bit is clear.
// - Starting edge and each reset edge assert PWM drive, unless duty is zero.
// - Drive drops at pulse-width match, stays low until halt or edge.
// - Period is (period+1) times four clocks times prescale.
// - Count equal to period clears on next increment.
// - Same increment sets pin, unless duty is zero.
// - Same increment loads duty pair into 10-bit buffer.
// - No postscaler affects PWM frequency.
// - The period timer is 8 bits wide.
module tosp_top (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Trigger and pin
  input wire logic i_trig,
  output logic o_pwm,
  output logic o_pwm_oe,
  // Interrupt
  output logic o_irq
);
  typedef struct packed {
    logic [7:0] period;
    logic [7:0] duty_lo;
    logic [7:0] duty_hi;
    logic [7:0] ctrl;
    logic [4:0] mode;
    logic [7:0] cmp;
    logic [7:0] count;
    logic [9:0] duty_buf;
    logic [2:0] status;
    logic [2:0] mask;
    logic trig_q;
    logic [1:0] hold;
    tosp_pkg::tosp_state_t st;
    logic pwm;
    logic irq;
    logic [7:0] rdata;
  } tosp_state_s_t;
  tosp_state_s_t s_q, s_d;

  logic tick;
  logic [1:0] frac;
  logic one_shot;
  logic edge_hit;
  logic [9:0] duty_pair;
  logic [9:0] count_ext;
  logic counting;

  tosp_prescale u_pre (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_run(s_q.ctrl[`TOSP_CTRL_ON]),
    .i_sel(s_q.ctrl[`TOSP_CTRL_PRESCALE_SELECT_HI:`TOSP_CTRL_PRESCALE_SELECT_LO]),
    .o_tick(tick),
    .o_frac(frac)
  );

  // alignment: left-justified puts top bits in the high byte
  always_comb begin
    if (s_q.cmp[`TOSP_CMP_FMT]) begin
      duty_pair = {s_q.duty_hi, s_q.duty_lo[7:6]};
    end else begin
      duty_pair = {s_q.duty_hi[1:0], s_q.duty_lo};
    end
  end

  assign one_shot = (s_q.mode == `TOSP_MODE_OS_RISE) || (s_q.mode == `TOSP_MODE_OS_FALL);
  assign edge_hit = (s_q.mode == `TOSP_MODE_OS_FALL) ? (s_q.trig_q && !i_trig) : (!s_q.trig_q && i_trig);
  assign count_ext = {s_q.count, frac};
  assign counting = (s_q.st == tosp_pkg::TOSP_RUN) || (!one_shot && s_q.ctrl[`TOSP_CTRL_ON]);

  always_comb begin
    s_d = s_q;
    s_d.trig_q = i_trig;
    s_d.rdata = 8'h00;
    // Register writes
    if (i_wr) begin
      case (i_addr)
        `TOSP_A_PERIOD: s_d.period = i_wdata;
        `TOSP_A_DUTY_LO: s_d.duty_lo = i_wdata;
        `TOSP_A_DUTY_HI: s_d.duty_hi = i_wdata;
        `TOSP_A_CTRL: s_d.ctrl = i_wdata;
        `TOSP_A_MODE: s_d.mode = i_wdata[4:0];
        `TOSP_A_COMPARE: s_d.cmp = i_wdata;
        `TOSP_A_COUNT: s_d.count = i_wdata;
        `TOSP_A_MASK: s_d.mask = i_wdata[2:0];
        default: ;
      endcase
    end
    // Reads; status clears on read, new events set below win
    if (i_rd) begin
      case (i_addr)
        `TOSP_A_PERIOD: s_d.rdata = s_q.period;
        `TOSP_A_DUTY_LO: s_d.rdata = s_q.duty_lo;
        `TOSP_A_DUTY_HI: s_d.rdata = s_q.duty_hi;
        `TOSP_A_CTRL: s_d.rdata = s_q.ctrl;
        `TOSP_A_MODE: s_d.rdata = {3'h0, s_q.mode};
        `TOSP_A_COMPARE: s_d.rdata = s_q.cmp;
        `TOSP_A_COUNT: s_d.rdata = s_q.count;
        `TOSP_A_STATUS: begin
          s_d.rdata = {5'h00, s_q.status};
          s_d.status = 3'h0;
        end
        `TOSP_A_MASK: s_d.rdata = {5'h00, s_q.mask};
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (!s_q.ctrl[`TOSP_CTRL_ON] || !s_d.ctrl[`TOSP_CTRL_ON]) begin
      s_d.st = tosp_pkg::TOSP_IDLE;
      if (s_d.ctrl[`TOSP_CTRL_ON]) begin
        s_d.st = tosp_pkg::TOSP_ARMED;
      end
    end else begin
      case (s_q.st)
        tosp_pkg::TOSP_IDLE: s_d.st = tosp_pkg::TOSP_ARMED;
        tosp_pkg::TOSP_ARMED: begin
          if (one_shot && edge_hit) begin
            s_d.st = tosp_pkg::TOSP_RUN;
            s_d.count = 8'h00;
            s_d.duty_buf = duty_pair;
            s_d.pwm = (duty_pair != 10'h000);
            s_d.status[`TOSP_ST_TRIG] = 1'b1;
          end
        end
        tosp_pkg::TOSP_RUN,
        tosp_pkg::TOSP_HOLD: begin
          if (s_q.st == tosp_pkg::TOSP_HOLD && tick) begin
            s_d.hold = 2'(s_q.hold - 2'h1);
            if (s_q.hold == 2'h1) begin
              s_d.st = tosp_pkg::TOSP_RUN;
            end
          end
          // later edge restarts after two timer clocks
          if (edge_hit) begin
            s_d.st = tosp_pkg::TOSP_HOLD;
            s_d.hold = `TOSP_RESTART_CLKS;
            s_d.count = 8'h00;
            s_d.duty_buf = duty_pair;
            s_d.pwm = (duty_pair != 10'h000);
            s_d.status[`TOSP_ST_TRIG] = 1'b1;
          end
        end
        default: s_d.st = tosp_pkg::TOSP_IDLE;
      endcase
    end
    // one-shot drive drops at pulse width match
    if (one_shot && counting && !edge_hit && s_q.count == s_q.duty_buf[9:2] && tick) begin
      s_d.pwm = 1'b0;
      s_d.status[`TOSP_ST_DUTY] = 1'b1;
    end
    // standard PWM clears at extended match
    if (!one_shot && counting && count_ext == s_q.duty_buf) begin
      if (s_q.pwm) begin
        s_d.status[`TOSP_ST_DUTY] = 1'b1;
      end
      s_d.pwm = 1'b0;
    end
    // 8-bit count advances once per prescaled tick
    if (counting && tick && !(one_shot && edge_hit)) begin
      if (s_q.count == s_q.period) begin
        s_d.count = 8'h00;
        s_d.status[`TOSP_ST_MATCH] = 1'b1;
        if (one_shot) begin
          s_d.ctrl[`TOSP_CTRL_ON] = 1'b0;
          s_d.st = tosp_pkg::TOSP_IDLE;
          s_d.pwm = 1'b0;
        end else begin
          s_d.duty_buf = duty_pair;
          s_d.pwm = (duty_pair != 10'h000);
        end
      end else begin
        s_d.count = 8'(s_q.count + 8'h01);
      end
    end
    if (!s_d.ctrl[`TOSP_CTRL_ON] && one_shot) begin
      s_d.pwm = s_d.pwm && counting && s_d.ctrl[`TOSP_CTRL_ON];
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.period <= `TOSP_RST_PERIOD;
      s_q.st <= tosp_pkg::TOSP_IDLE;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_pwm = s_q.pwm;
  assign o_pwm_oe = s_q.cmp[`TOSP_CMP_EN];
  assign o_irq = s_q.irq;

  halt_clears_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && one_shot && counting && tick && !edge_hit && s_q.count == s_q.period && !i_wr
    |=> !s_q.ctrl[`TOSP_CTRL_ON] && s_q.count == 8'h00)
    else $error("one-shot period match did not halt");

  idle_ignore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !s_q.ctrl[`TOSP_CTRL_ON] && !i_wr |=> s_q.st != tosp_pkg::TOSP_RUN)
    else $error("edge accepted while halted");

  first_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && one_shot && s_q.st == tosp_pkg::TOSP_ARMED && edge_hit && !i_wr
    |=> s_q.st == tosp_pkg::TOSP_RUN)
    else $error("armed timer did not start on edge");

  restart_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && one_shot && s_q.st == tosp_pkg::TOSP_RUN && edge_hit && !i_wr
    |=> s_q.count == 8'h00 && s_q.st == tosp_pkg::TOSP_HOLD)
    else $error("reset edge did not clear count");

  edge_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && one_shot && s_q.st == tosp_pkg::TOSP_ARMED && edge_hit && !i_wr && duty_pair != 10'h000
    |=> s_q.pwm)
    else $error("start edge did not assert drive");

  zero_duty_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !one_shot && counting && tick && s_q.count == s_q.period && duty_pair == 10'h000
    |=> !s_q.pwm)
    else $error("pin set with zero duty");

  duty_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !one_shot && counting && tick && s_q.count == s_q.period && !i_wr
    |=> s_q.duty_buf == $past(duty_pair))
    else $error("duty not buffered at period");

  count_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !one_shot && counting && tick && s_q.count == s_q.period && !i_wr
    |=> s_q.count == 8'h00)
    else $error("count did not clear at period");

  width_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && one_shot && counting && tick && !edge_hit && s_q.count == s_q.duty_buf[9:2]
    |=> !s_q.pwm)
    else $error("drive stayed on past width match");

  restart_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && one_shot && (s_q.st == tosp_pkg::TOSP_RUN || s_q.st == tosp_pkg::TOSP_HOLD) && edge_hit
    && !i_wr && duty_pair != 10'h000 |=> s_q.pwm)
    else $error("reset edge did not assert drive");

  hold_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && one_shot && s_q.st == tosp_pkg::TOSP_HOLD && !i_wr |=> s_q.count == 8'h00)
    else $error("count moved during restart holdoff");

  std_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !one_shot && counting && count_ext == s_q.duty_buf && !(tick && s_q.count == s_q.period)
    |=> !s_q.pwm)
    else $error("pin not cleared at duty match");

  wrap_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !one_shot && counting && tick && s_q.count == s_q.period && duty_pair != 10'h000
    |=> s_q.pwm)
    else $error("pin not set at period wrap");

  // timer clock at most quarter rate
  tick_space_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && tick |=> !tick [*3])
    else $error("timer ticks closer than four clocks");
endmodule

//--- testbench/test_timer_one_shot_pwm.sv
`timescale 1ns/10ps
`include "tosp_regs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("unexpected %s exp %h got %h", n, e, g); end end
module test_timer_one_shot_pwm;
  typedef struct {logic [7:0] per; logic [2:0] ps; logic fmt; logic [9:0] duty; int ep; int eh;} tosp_row_t;
  logic clk, rst_n, wr, rd, trig, pwm, oe, irq, act, ce;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  int fails = 0;
  int check_count = 0;
  int n;
  logic [4:0] md [2] = '{`TOSP_MODE_OS_RISE, `TOSP_MODE_OS_FALL};
  // Pin drops one clock after the extended match is seen
  tosp_row_t rows [3] = '{'{8'h09, 3'h0, 1'b0, 10'h00c, 40, 13}, '{8'h04, 3'h1, 1'b1, 10'h008, 40, 17},
    '{8'h01, 3'h2, 1'b0, 10'h005, 32, 20}};

  tosp_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_trig(trig), .o_pwm(pwm), .o_pwm_oe(oe), .o_irq(irq));
  tosp_partner p (.i_clk(clk), .i_pwm(pwm), .o_trig(trig));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic wait_pwm(input logic lvl, input int lim);
    n = 0;
    while (pwm !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    close_out;
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdr(`TOSP_A_PERIOD);
    `CHK("period reset", 8'hff, v)
    rdr(4'hf);
    `CHK("unmapped read", 8'h00, v)
    foreach (rows[i]) begin
      wrr(`TOSP_A_CTRL, 8'h00);
      wrr(`TOSP_A_MODE, {3'h0, `TOSP_MODE_FREE});
      wrr(`TOSP_A_PERIOD, rows[i].per);
      wrr(`TOSP_A_COMPARE, {3'h0, rows[i].fmt, 4'h0});
      wrr(`TOSP_A_DUTY_LO, rows[i].fmt ? {rows[i].duty[1:0], 6'h00} : rows[i].duty[7:0]);
      wrr(`TOSP_A_DUTY_HI, rows[i].fmt ? rows[i].duty[9:2] : {6'h00, rows[i].duty[9:8]});
      rdr(`TOSP_A_STATUS);
      wrr(`TOSP_A_CTRL, {1'b1, rows[i].ps, 4'h0});
      v = 8'h00;
      n = 0;
      while (v[0] !== 1'b1 && n < 300) begin
        rdr(`TOSP_A_STATUS);
        n++;
      end
      `CHK("match flag", 1'b1, v[`TOSP_ST_MATCH])
      wrr(`TOSP_A_COMPARE, {3'h4, rows[i].fmt, 4'h0});
      @(posedge clk);
      #1;
      `CHK("pin enable", 1'b1, oe)
      n = p.rises + 3;
      repeat (2000) if (p.rises < n) @(posedge clk);
      #1;
      `CHK("period cycles", rows[i].ep, p.per_len)
      `CHK("high cycles", rows[i].eh, p.hi_len)
    end
    // Clock enable low freezes timer and pin
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    n = p.rises;
    repeat (64) @(posedge clk);
    `CHK("frozen rises", n, p.rises)
    ce <= 1'b1;
    wrr(`TOSP_A_DUTY_LO, 8'h00);
    wrr(`TOSP_A_DUTY_HI, 8'h00);
    repeat (20) @(posedge clk);
    n = p.rises;
    repeat (40) @(posedge clk);
    #1;
    `CHK("zero duty rises", n, p.rises)
    `CHK("zero duty pin", 1'b0, pwm)
    wrr(`TOSP_A_MASK, 8'h01);
    repeat (100) if (irq !== 1'b1) @(posedge clk);
    #1;
    `CHK("irq raised", 1'b1, irq)
    wrr(`TOSP_A_MASK, 8'h00);
    @(posedge clk);
    #1;
    `CHK("irq masked", 1'b0, irq)
    rdr(`TOSP_A_STATUS);
    `CHK("status held", 1'b1, v[`TOSP_ST_MATCH])
    foreach (md[j]) begin
      act = (j == 0);
      wrr(`TOSP_A_CTRL, 8'h00);
      wrr(`TOSP_A_PERIOD, 8'h0f);
      wrr(`TOSP_A_DUTY_LO, 8'h14);
      wrr(`TOSP_A_MODE, {3'h0, md[j]});
      p.set_level(act);
      p.set_level(!act);
      `CHK("edge while stopped", 1'b0, pwm)
      wrr(`TOSP_A_CTRL, 8'h80);
      p.set_level(act);
      wait_pwm(1'b1, 8);
      `CHK("start edge", 1'b1, pwm)
      wait_pwm(1'b0, 40);
      @(negedge clk);
      #1;
      `CHK("first high", 1'b1, p.hi_len >= 15 && p.hi_len <= 23)
      p.set_level(!act);
      p.set_level(act);
      wait_pwm(1'b1, 8);
      `CHK("restart edge", 1'b1, pwm)
      wait_pwm(1'b0, 60);
      @(negedge clk);
      #1;
      `CHK("restart high", 1'b1, p.hi_len >= 24 && p.hi_len <= 33)
      repeat (80) @(posedge clk);
      rdr(`TOSP_A_CTRL);
      `CHK("run cleared", 1'b0, v[`TOSP_CTRL_ON])
      `CHK("halted pin", 1'b0, pwm)
    end
    wrr(`TOSP_A_COUNT, 8'h5a);
    rdr(`TOSP_A_COUNT);
    `CHK("count readback", 8'h5a, v)
    rdr(`TOSP_A_STATUS);
    rdr(`TOSP_A_STATUS);
    `CHK("status cleared", 8'h00, v)
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    `CHK("reset pin", 1'b0, pwm)
    `CHK("reset enable", 1'b0, oe)
    close_out;
  end
endmodule

//--- testbench/tosp_partner.sv
`timescale 1ns/10ps
module tosp_partner (
  // Clock
  input wire logic i_clk,
  // Pin and trigger
  input wire logic i_pwm,
  output logic o_trig
);
  int hi_len = 0;
  int per_len = 0;
  int rises = 0;
  int run_hi = 0;
  int run_per = 0;
  logic last_q = 1'b0;

  initial begin
    o_trig = 1'b0;
  end

  // Falling edge sampling keeps clear of the pin's own update edge
  always @(negedge i_clk) begin
    last_q <= i_pwm;
    run_per <= run_per + 1;
    if (i_pwm === 1'b1) begin
      run_hi <= run_hi + 1;
    end
    if (i_pwm === 1'b1 && last_q === 1'b0) begin
      rises <= rises + 1;
      per_len <= run_per;
      run_per <= 1;
      run_hi <= 1;
    end
    if (i_pwm === 1'b0 && last_q === 1'b1) begin
      hi_len <= run_hi;
    end
  end

  // Each level is held so the edge detector sees it
  task automatic set_level(input logic lvl);
    @(posedge i_clk);
    o_trig <= lvl;
    repeat (3) @(posedge i_clk);
  endtask
endmodule
